// >>> hdl/lpm_ctrl.sv
`timescale 1ns/10ps
// Functional notes
// - stop instruction from the cpu halts the on-chip oscillator and enters low power
// - with snooze off, interval timer interrupt wakes from low power and starts a conversion
// - normal mode keeps all clocks and all peripherals running
// - halt keeps every running clock running and stops only cpu execution
// - an irq_req interrupt request leaves halt at once, no oscillator restart delay
// - snooze: serial reception leaves stop, data captured with the cpu held
// - snooze: rtc, interval or timer channel trigger runs a conversion without cpu
// - snooze may be enabled only while the on-chip oscillator clocks cpu and peripherals
// - conversion result outside win_lo..win_hi (0xc8..0xff at reset) ends snooze and wakes the cpu
// - stop turns off both the system oscillator and the on-chip oscillator
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int ADC_W = LPM_ADC_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cpu_stop_exec,
  input wire logic cpu_halt_exec,
  input wire logic irq_req,
  input wire logic interval_timer_interrupt,
  input wire logic rtc_interrupt,
  input wire logic timer_channel_interrupt,
  input wire logic clocked_serial_channel_rx_valid,
  input wire logic [7:0] clocked_serial_channel_rx_data,
  input wire logic async_serial_channel_rx_valid,
  input wire logic [7:0] async_serial_channel_rx_data,
  input wire logic adc_done,
  input wire logic [ADC_W-1:0] adc_result,
  output logic hoco_en,
  output logic xo_en,
  output logic periph_clk_en,
  output logic cpu_run,
  output logic adc_start,
  output logic serial_capture,
  output logic [2:0] lpm_mode,
  output logic irq
);

  lpm_state_t state;
  lpm_state_t next_state;
  logic clk_src_hoco;
  logic snooze_en;
  logic [LPM_EV_N-1:0] int_stat;
  logic [LPM_EV_N-1:0] int_mask;
  logic [LPM_EV_N-1:0] next_int_stat;
  logic [LPM_EV_N-1:0] next_int_mask;
  logic [LPM_EV_N-1:0] ev;
  logic [ADC_W-1:0] win_lo;
  logic [ADC_W-1:0] win_hi;
  logic [ADC_W-1:0] adc_last;
  logic [8:0] ser_data;
  logic acc;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  logic out_win;
  logic ser_rx;
  logic conv_trig;
  logic next_adc_start;

  // ---------------- ahb-lite slave, zero wait states ----------------
  assign acc = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      LPM_CTRL_OFF: begin
        next_rdata[LPM_CTRL_HOCO_BIT] = clk_src_hoco;
        next_rdata[LPM_CTRL_SNZ_BIT] = snooze_en;
      end
      LPM_STATUS_OFF: begin
        next_rdata[LPM_STATUS_MODE_LSB +: 3] = state;
        next_rdata[LPM_STATUS_HOCO_BIT] = hoco_en;
        next_rdata[LPM_STATUS_XO_BIT] = xo_en;
        next_rdata[LPM_STATUS_CPU_BIT] = cpu_run;
      end
      LPM_INT_STAT_OFF: next_rdata[LPM_EV_N-1:0] = int_stat;
      LPM_INT_MASK_OFF: next_rdata[LPM_EV_N-1:0] = int_mask;
      LPM_WIN_LO_OFF: next_rdata[ADC_W-1:0] = win_lo;
      LPM_WIN_HI_OFF: next_rdata[ADC_W-1:0] = win_hi;
      LPM_ADC_LAST_OFF: next_rdata[ADC_W-1:0] = adc_last;
      LPM_SER_DATA_OFF: next_rdata[8:0] = ser_data;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (acc && !hwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // ---------------- software controls ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_src_hoco <= LPM_CTRL_HOCO_RST;
      snooze_en <= LPM_CTRL_SNZ_RST;
    end else if (wr_pend && wr_addr == LPM_CTRL_OFF) begin
      clk_src_hoco <= hwdata[LPM_CTRL_HOCO_BIT];
      // snooze is refused unless the on-chip oscillator stays the clock source
      snooze_en <= hwdata[LPM_CTRL_SNZ_BIT] && hwdata[LPM_CTRL_HOCO_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_lo <= ADC_W'(LPM_WIN_LO_RST);
      win_hi <= ADC_W'(LPM_WIN_HI_RST);
    end else if (wr_pend && wr_addr == LPM_WIN_LO_OFF) begin
      win_lo <= hwdata[ADC_W-1:0];
    end else if (wr_pend && wr_addr == LPM_WIN_HI_OFF) begin
      win_hi <= hwdata[ADC_W-1:0];
    end
  end

  // the interrupt flop sees the mask of the same edge, so irq never lags a mask write
  always_comb begin
    next_int_mask = int_mask;
    if (wr_pend && wr_addr == LPM_INT_MASK_OFF) begin
      next_int_mask = hwdata[LPM_EV_N-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask <= LPM_INT_MASK_RST;
    end else begin
      int_mask <= next_int_mask;
    end
  end

  // ---------------- mode sequencer ----------------
  lpm_win_cmp #(
    .W(ADC_W)
  ) u_win (
    .value(adc_result),
    .lower(win_lo),
    .upper(win_hi),
    .outside(out_win)
  );

  assign ser_rx = clocked_serial_channel_rx_valid || async_serial_channel_rx_valid;
  assign conv_trig = rtc_interrupt || interval_timer_interrupt || timer_channel_interrupt;

  always_comb begin
    next_state = state;
    next_adc_start = 1'b0;
    unique case (state)
      LPM_NORMAL: begin
        if (cpu_stop_exec) begin
          next_state = LPM_STOP;
        end else if (cpu_halt_exec) begin
          next_state = LPM_HALT;
        end
      end
      LPM_HALT: begin
        if (irq_req) begin
          next_state = LPM_NORMAL;
        end
      end
      LPM_STOP: begin
        if (snooze_en && ser_rx) begin
          next_state = LPM_SNZ_SER;
        end else if (snooze_en && conv_trig) begin
          next_state = LPM_SNZ_ADC;
          next_adc_start = 1'b1;
        end else if (interval_timer_interrupt) begin
          next_state = LPM_NORMAL;
          next_adc_start = 1'b1;
        end else if (irq_req) begin
          next_state = LPM_NORMAL;
        end
      end
      LPM_SNZ_SER: begin
        next_state = LPM_STOP;
      end
      LPM_SNZ_ADC: begin
        if (adc_done) begin
          next_state = out_win ? LPM_NORMAL : LPM_STOP;
        end
      end
      default: next_state = LPM_NORMAL;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= LPM_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  assign lpm_mode = state;

  // clock and execution enables follow the state they lead into
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hoco_en <= 1'b1;
      xo_en <= 1'b1;
      periph_clk_en <= 1'b1;
      cpu_run <= 1'b1;
    end else begin
      hoco_en <= next_state != LPM_STOP;
      xo_en <= next_state inside {LPM_NORMAL, LPM_HALT};
      periph_clk_en <= next_state != LPM_STOP;
      cpu_run <= next_state == LPM_NORMAL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_start <= 1'b0;
      serial_capture <= 1'b0;
    end else begin
      adc_start <= next_adc_start;
      serial_capture <= state == LPM_STOP && next_state == LPM_SNZ_SER;
    end
  end

  // serial byte taken in snooze; the clocked channel wins a tie
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_data <= 9'h000;
    end else if (state == LPM_STOP && next_state == LPM_SNZ_SER) begin
      if (clocked_serial_channel_rx_valid) begin
        ser_data <= {1'b0, clocked_serial_channel_rx_data};
      end else begin
        ser_data <= {1'b1, async_serial_channel_rx_data};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_last <= '0;
    end else if (adc_done) begin
      adc_last <= adc_result;
    end
  end

  // ---------------- events and interrupt ----------------
  always_comb begin
    ev = '0;
    ev[LPM_EV_STOP] = state != LPM_STOP && next_state == LPM_STOP;
    ev[LPM_EV_WAKE] = state != LPM_NORMAL && next_state == LPM_NORMAL;
    ev[LPM_EV_WIN] = state == LPM_SNZ_ADC && adc_done && out_win;
    ev[LPM_EV_SER] = state == LPM_SNZ_SER;
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    next_int_stat = int_stat;
    if (wr_pend && wr_addr == LPM_INT_STAT_OFF) begin
      next_int_stat = int_stat & ~hwdata[LPM_EV_N-1:0];
    end
    next_int_stat = next_int_stat | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= LPM_INT_STAT_RST;
      irq <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      irq <= |(next_int_stat & next_int_mask);
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  stop_entry_a: assert property (state == LPM_NORMAL && cpu_stop_exec
    |=> state == LPM_STOP && !hoco_en && !cpu_run)
    else $error("stop instruction did not stop the on-chip oscillator");

  it_wake_conv_a: assert property (state == LPM_STOP && interval_timer_interrupt
    && !(snooze_en && ser_rx) |=> adc_start && state != LPM_STOP)
    else $error("interval timer wake did not start a conversion");

  normal_clocks_a: assert property (state == LPM_NORMAL
    |-> hoco_en && xo_en && periph_clk_en && cpu_run)
    else $error("clock off in normal mode");

  halt_clocks_a: assert property (state == LPM_NORMAL && cpu_halt_exec && !cpu_stop_exec
    |=> state == LPM_HALT && !cpu_run && hoco_en && xo_en && periph_clk_en)
    else $error("halt changed a running clock");

  halt_wake_a: assert property (state == LPM_HALT && irq_req
    |=> cpu_run && state == LPM_NORMAL)
    else $error("halt not left in one cycle on interrupt");

  snz_serial_a: assert property (state == LPM_STOP && snooze_en && ser_rx
    |=> serial_capture && !cpu_run ##1 state == LPM_STOP && !serial_capture)
    else $error("snooze serial capture sequence wrong");

  snz_conv_a: assert property (state == LPM_STOP && snooze_en && !ser_rx
    && (rtc_interrupt || timer_channel_interrupt) |=> adc_start && !cpu_run
    && state == LPM_SNZ_ADC)
    else $error("snooze trigger did not start a conversion");

  snz_source_a: assert property (snooze_en |-> clk_src_hoco)
    else $error("snooze enabled without on-chip oscillator clock");

  win_exit_a: assert property (state == LPM_SNZ_ADC && adc_done && out_win
    |=> cpu_run ##1 int_stat[LPM_EV_WIN])
    else $error("out of window result did not wake the cpu");

  stop_osc_a: assert property (state == LPM_STOP
    |-> !hoco_en && !xo_en && !periph_clk_en)
    else $error("oscillator running in stop");

  win_return_a: assert property (state == LPM_SNZ_ADC && adc_done && !out_win
    |=> state == LPM_STOP && !cpu_run && !hoco_en)
    else $error("in window result did not return to stop");

  irq_level_a: assert property (|(int_stat & int_mask) |-> irq)
    else $error("interrupt low with unmasked status set");

  halt_cycle_c: cover property (state == LPM_NORMAL ##1 state == LPM_HALT
    ##[1:20] state == LPM_NORMAL);
  snz_return_c: cover property (state == LPM_SNZ_ADC ##1 state == LPM_STOP);
  snz_wake_c: cover property (state == LPM_SNZ_ADC && adc_done && out_win);
  snz_serial_c: cover property (state == LPM_SNZ_SER);

endmodule : lpm_ctrl

// >>> hdl/lpm_pkg.sv
package lpm_pkg;

  // ahb register byte offsets
  localparam logic [7:0] LPM_CTRL_OFF = 8'h00;
  localparam logic [7:0] LPM_STATUS_OFF = 8'h04;
  localparam logic [7:0] LPM_INT_STAT_OFF = 8'h08;
  localparam logic [7:0] LPM_INT_MASK_OFF = 8'h0c;
  localparam logic [7:0] LPM_WIN_LO_OFF = 8'h10;
  localparam logic [7:0] LPM_WIN_HI_OFF = 8'h14;
  localparam logic [7:0] LPM_ADC_LAST_OFF = 8'h18;
  localparam logic [7:0] LPM_SER_DATA_OFF = 8'h1c;

  // control register fields
  localparam int LPM_CTRL_HOCO_BIT = 0;
  localparam int LPM_CTRL_SNZ_BIT = 1;
  localparam logic LPM_CTRL_HOCO_RST = 1'b1;
  localparam logic LPM_CTRL_SNZ_RST = 1'b0;

  // status register fields
  localparam int LPM_STATUS_MODE_LSB = 0;
  localparam int LPM_STATUS_HOCO_BIT = 4;
  localparam int LPM_STATUS_XO_BIT = 5;
  localparam int LPM_STATUS_CPU_BIT = 6;

  // serial capture register: channel flag above the data byte
  localparam int LPM_SER_CHAN_BIT = 8;

  // event bits of int_stat and int_mask
  localparam int LPM_EV_N = 4;
  localparam int LPM_EV_STOP = 0;
  localparam int LPM_EV_WAKE = 1;
  localparam int LPM_EV_WIN = 2;
  localparam int LPM_EV_SER = 3;
  localparam logic [LPM_EV_N-1:0] LPM_INT_STAT_RST = 4'h0;
  localparam logic [LPM_EV_N-1:0] LPM_INT_MASK_RST = 4'h0;

  // conversion result window
  localparam int LPM_ADC_W = 8;
  localparam logic [7:0] LPM_WIN_LO_RST = 8'hc8;
  localparam logic [7:0] LPM_WIN_HI_RST = 8'hff;

  typedef enum logic [2:0] {
    LPM_NORMAL = 3'b000,
    LPM_HALT = 3'b001,
    LPM_STOP = 3'b010,
    LPM_SNZ_ADC = 3'b011,
    LPM_SNZ_SER = 3'b100
  } lpm_state_t;

endpackage : lpm_pkg

// >>> hdl/lpm_win_cmp.sv
`timescale 1ns/10ps
module lpm_win_cmp #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] lower,
  input wire logic [W-1:0] upper,
  output logic outside
);

  // strictly below the lower bound or strictly above the upper bound
  assign outside = (value < lower) || (value > upper);

endmodule : lpm_win_cmp

// >>> testbench/lpm_far_end.sv
`timescale 1ns/10ps
module lpm_far_end (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic adc_start,
  input wire logic [7:0] next_result,
  input wire logic [3:0] latency,
  output logic adc_done,
  output logic [7:0] adc_result
);
  logic [7:0] held;
  int cnt;
  // converter: answers latency plus one cycles after a start, data only valid with done
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= -1;
      held <= 8'h00;
      adc_done <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      if (adc_start) begin
        cnt <= latency;
        held <= next_result;
      end else if (cnt == 0) begin
        adc_done <= 1'b1;
        cnt <= -1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // result bus carries junk outside the done cycle
  assign adc_result = adc_done ? held : ~held;
endmodule : lpm_far_end

// >>> testbench/test_low_power_mode_control.sv
`timescale 1ns/10ps
module test_low_power_mode_control;
  import lpm_pkg::*;
  logic hclk, hresetn, hwrite, hready, hreadyout, hresp, adc_done, snz;
  logic hoco_en, xo_en, periph_clk_en, cpu_run, adc_start, serial_capture, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] ev, cs_data, as_data, adc_result, next_result;
  logic [3:0] latency;
  logic [2:0] lpm_mode;
  logic [7:0] res_q[$];
  logic [7:0] bnd [4] = '{8'hc7, 8'hc8, 8'hff, 8'h00};
  logic [31:0] rst_tab [7] = '{32'h1, 32'h70, 32'h0, 32'h0, 32'hc8, 32'hff, 32'h0};
  int fails, tests_run, seed, exp_mode, i;

  assign hready = hreadyout;
  lpm_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpu_stop_exec(ev[0]), .cpu_halt_exec(ev[1]),
    .irq_req(ev[2]), .interval_timer_interrupt(ev[3]), .rtc_interrupt(ev[4]),
    .timer_channel_interrupt(ev[5]), .clocked_serial_channel_rx_valid(ev[6]),
    .clocked_serial_channel_rx_data(cs_data), .async_serial_channel_rx_valid(ev[7]),
    .async_serial_channel_rx_data(as_data), .adc_done(adc_done), .adc_result(adc_result),
    .hoco_en(hoco_en), .xo_en(xo_en), .periph_clk_en(periph_clk_en), .cpu_run(cpu_run),
    .adc_start(adc_start), .serial_capture(serial_capture), .lpm_mode(lpm_mode), .irq(irq));
  lpm_far_end adc (.hclk(hclk), .hresetn(hresetn), .adc_start(adc_start),
    .next_result(next_result), .latency(latency), .adc_done(adc_done),
    .adc_result(adc_result));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task summarize;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task chk_mode(input int m);
    logic [3:0] en;
    en = (m == 0) ? 4'hf : (m == 1) ? 4'he : (m == 2) ? 4'h0 : 4'ha;
    chk({29'h0, lpm_mode}, m, "mode");
    chk({28'h0, hoco_en, xo_en, periph_clk_en, cpu_run}, {28'h0, en}, "enables");
  endtask : chk_mode

  task wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      summarize();
    end
  endtask : wt

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wt();
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : ahb

  function automatic int nxt(input int m, input int b);
    if (m == 0 && b < 2) return b == 0 ? 2 : 1;
    if (m == 1 && b == 2) return 0;
    if (m == 2 && snz && b > 5) return 4;
    if (m == 2 && snz && b > 2) return 3;
    if (m == 2 && (b == 3 || b == 2)) return 0;
    return m;
  endfunction : nxt

  task step(input int b);
    int old;
    int k;
    logic st;
    old = exp_mode;
    exp_mode = nxt(old, b);
    st = old == 2 && (exp_mode == 3 || (b == 3 && exp_mode == 0));
    @(posedge hclk);
    ev <= 8'h1 << b;
    @(posedge hclk);
    ev <= 8'h0;
    #1;
    chk_mode(exp_mode);
    chk(adc_start, st, "start");
    chk(serial_capture, exp_mode == 4, "capture");
    if (exp_mode == 4) begin
      @(posedge hclk);
      #1;
      exp_mode = 2;
      chk_mode(2);
    end
    if (st) begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (adc_done !== 1'b1 && k < 50);
      #1;
      chk(k < 50, 1, "done wait");
      if (exp_mode == 3) exp_mode = next_result < 8'hc8 ? 0 : 2;
      chk_mode(exp_mode);
      res_q.push_back(next_result);
    end
  endtask : step

  initial begin
    hresetn = 1'b0;
    {ev, cs_data, as_data, next_result, latency, htrans, hwrite} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    {fails, tests_run, exp_mode} = '0;
    snz = 1'b0;
    seed = 99505;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk_mode(0);
    ahb(1, 8'h20, 32'hffffffff, rd);
    ahb(1, LPM_STATUS_OFF, 32'hffffffff, rd);
    for (i = 0; i < 7; i++) begin
      ahb(0, i == 6 ? 8'h20 : 8'(i * 4), 32'h0, rd);
      chk(rd, rst_tab[i], "reset value");
    end
    step(1);
    step(2);
    step(0);
    step(4);
    step(3);
    step(0);
    step(2);
    ahb(1, LPM_CTRL_OFF, 32'h2, rd);
    ahb(0, LPM_CTRL_OFF, 32'h0, rd);
    chk(rd[1:0], 2'h0, "snooze refused");
    ahb(1, LPM_CTRL_OFF, 32'h3, rd);
    ahb(0, LPM_CTRL_OFF, 32'h0, rd);
    chk(rd[1:0], 2'h3, "snooze on");
    snz = 1'b1;
    for (i = 0; i < 8; i++) begin
      if (exp_mode == 0) step(0);
      next_result <= i < 4 ? bnd[i] : 8'($random(seed));
      latency <= 4'($random(seed)) & 4'h7;
      step(3 + i % 3);
      ahb(0, LPM_ADC_LAST_OFF, 32'h0, rd);
      chk(rd, {24'h0, res_q[$]}, "adc last");
    end
    if (exp_mode == 0) step(0);
    for (i = 0; i < 2; i++) begin
      cs_data <= 8'($random(seed));
      as_data <= 8'($random(seed));
      step(6 + i);
      ahb(0, LPM_SER_DATA_OFF, 32'h0, rd);
      chk(rd, {23'h0, i[0], i[0] ? as_data : cs_data}, "serial data");
    end
    step(2);
    ahb(1, LPM_INT_MASK_OFF, 32'h0, rd);
    ahb(1, LPM_INT_STAT_OFF, 32'hf, rd);
    step(0);
    ahb(0, LPM_INT_STAT_OFF, 32'h0, rd);
    chk(rd, 32'h1, "stop event");
    chk(irq, 1'b0, "masked irq");
    ahb(1, LPM_INT_MASK_OFF, 32'h1, rd);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 1'b1, "irq raised");
    ahb(1, LPM_INT_STAT_OFF, 32'h1, rd);
    repeat (2) @(posedge hclk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    ahb(0, LPM_INT_STAT_OFF, 32'h0, rd);
    chk(rd, 32'h0, "stat cleared");
    summarize();
  end

  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule : test_low_power_mode_control
